// ===== pkg/spd_div_if.sv
`timescale 1ns/1ps
interface spd_div_if;
  logic evt;
  logic run;
  logic msel;
  logic [7:0] swal;
  logic [10:0] main_n;
  logic fp;
  logic hi_mod;
  modport core(output evt, run, msel, swal, main_n, input fp, hi_mod);
  modport div(input evt, run, msel, swal, main_n, output fp, hi_mod);
endinterface : spd_div_if

// ===== pkg/spd_pkg.sv
package spd_pkg;
  // ==========================================
  // serial word layout
  localparam int SR_W = 20;
  localparam int REF_LATCH_W = 15;
  localparam int DIV_LATCH_W = 19;
  localparam int SWAL_W = 8;
  localparam int MAIN_W = 11;
  localparam int REF_CNT_W = 14;
  localparam int SR_CTRL_POS = 0;
  localparam int SR_REF_HI = 15;
  localparam int SR_LO = 1;
  localparam int REF_MSEL_POS = 14;
  localparam int DIV_MAIN_LO = 8;
  // ==========================================
  // divide ranges and prescaler pairs
  localparam logic [MAIN_W-1:0] MAIN_MIN = 11'h010;
  localparam logic [REF_CNT_W-1:0] REF_MIN = 14'h0008;
  localparam logic [8:0] PRE_SMALL = 9'h080;
  localparam logic [8:0] PRE_LARGE = 9'h100;
  // ==========================================
  // pin sampling
  localparam int PIN_N = 6;
  localparam int PIN_DATA = 0;
  localparam int PIN_SCLK = 1;
  localparam int PIN_STROBE = 2;
  localparam int PIN_POL = 3;
  localparam int PIN_PRE = 4;
  localparam int PIN_OSC = 5;
  localparam logic [PIN_N-1:0] PIN_RST = 6'h08;
  // ==========================================
  // register map and reset values
  localparam logic [31:0] REG_CTRL = 32'h0000_0000;
  localparam logic [31:0] REG_REF = 32'h0000_0004;
  localparam logic [31:0] REG_DIV = 32'h0000_0008;
  localparam logic [31:0] REG_STAT = 32'h0000_000c;
  localparam int CTRL_RUN_POS = 0;
  localparam logic CTRL_RUN_RST = 1'b1;
  localparam logic [REF_LATCH_W-1:0] REF_LATCH_RST = 15'h0008;
  localparam logic [DIV_LATCH_W-1:0] DIV_LATCH_RST = 19'h01000;
  localparam int STAT_LOCK = 0;
  localparam int STAT_UP = 1;
  localparam int STAT_DN = 2;
  localparam int STAT_POL = 3;
  localparam int STAT_STROBE = 4;
  localparam int STAT_BADSET = 5;
  localparam int STAT_HIMOD = 6;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : spd_pkg

// ===== rtl/spd_core.sv
`timescale 1ns/1ps
// Function
// - each shift clock rise shifts one data bit; 20-bit and 16-bit words
// - control bit high with strobe high loads the 15-bit reference latch
// - control bit low with strobe high loads the 19-bit divider latch
// - a high strobe is active and loads while it stays high
// - divider latch splits into 8-bit swallow and 11-bit main value
// - main counter divides 16 to 2047; host keeps within range
// - reference latch is 14-bit counter value plus modulus select bit
// - modulus select picks prescaler pair; swallow count picks modulus
// - lock output rests high, low while a phase difference exists
// - low polarity select inverts comparator and pump sense
// - monitor follows divided reference or divided vco by polarity
// - fast-lock switch floats, drives pump output while strobe high
// - two detector outputs follow polarity; one is open drain
// - modulus select high means 128/129, low means 256/257
module spd_core #(
  parameter int ADDR_W = 12
) (
  // clock, reset, enable
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // axi4-lite slave
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // serial load pins
  input wire logic serial_data_in,
  input wire logic serial_shift_clk,
  input wire logic latch_load_strobe,
  // control and clock pins
  input wire logic phase_polarity_select,
  input wire logic prescaler_input,
  input wire logic reference_osc_input,
  // synthesizer outputs
  output logic lock_indicator_out,
  output logic monitor_out,
  output logic charge_pump_out,
  output logic charge_pump_oe,
  output logic fast_lock_switch_out,
  output logic fast_lock_switch_oe,
  output logic phase_ref_out,
  output logic phase_vco_pull_out,
  output logic phase_vco_pull_oe,
  output logic prescaler_modulus_select,
  output logic prescaler_high_modulus
);
  if (ADDR_W < 4 || ADDR_W > 32) begin : g_chk
    $error("ADDR_W must lie between 4 and 32");
  end

  spd_div_if dif ();

  // ==========================================
  // pin synchronisers
  logic [spd_pkg::PIN_N-1:0] s1_reg, s2_reg, s3_reg, filt_reg;
  logic [spd_pkg::PIN_N-1:0] filt_next, agree, rise;

  always_comb begin
    // a level counts only once the last two stages agree
    agree = ~(s2_reg ^ s3_reg);
    filt_next = (agree & s2_reg) | (~agree & filt_reg);
    rise = filt_next & ~filt_reg;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s1_reg <= spd_pkg::PIN_RST;
      s2_reg <= spd_pkg::PIN_RST;
      s3_reg <= spd_pkg::PIN_RST;
      filt_reg <= spd_pkg::PIN_RST;
    end else if (ce) begin
      s1_reg <= {reference_osc_input, prescaler_input, phase_polarity_select,
                 latch_load_strobe, serial_shift_clk, serial_data_in};
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      filt_reg <= filt_next;
    end
  end

  logic strobe, pol;
  assign strobe = filt_reg[spd_pkg::PIN_STROBE];
  assign pol = filt_reg[spd_pkg::PIN_POL];

  // ==========================================
  // shift register and latches
  logic [spd_pkg::SR_W-1:0] shift_reg, shift_next;
  logic [spd_pkg::REF_LATCH_W-1:0] ref_latch_reg, ref_latch_next, sr_ref;
  logic [spd_pkg::DIV_LATCH_W-1:0] div_latch_reg, div_latch_next, sr_div;

  assign sr_ref = shift_reg[spd_pkg::SR_REF_HI:spd_pkg::SR_LO];
  assign sr_div = shift_reg[spd_pkg::SR_W-1:spd_pkg::SR_LO];

  always_comb begin
    shift_next = shift_reg;
    ref_latch_next = ref_latch_reg;
    div_latch_next = div_latch_reg;
    // one register serves both words; the short word uses its low 16 bits
    if (rise[spd_pkg::PIN_SCLK])
      shift_next = {shift_reg[spd_pkg::SR_W-2:0],
                    filt_next[spd_pkg::PIN_DATA]};
    if (strobe) begin
      if (shift_reg[spd_pkg::SR_CTRL_POS])
        ref_latch_next = sr_ref;
      else
        div_latch_next = sr_div;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      shift_reg <= '0;
      ref_latch_reg <= spd_pkg::REF_LATCH_RST;
      div_latch_reg <= spd_pkg::DIV_LATCH_RST;
    end else if (ce) begin
      shift_reg <= shift_next;
      ref_latch_reg <= ref_latch_next;
      div_latch_reg <= div_latch_next;
    end
  end

  // ==========================================
  // reference divider and divider hookup
  logic ctrl_run_reg, ctrl_run_next;
  logic [spd_pkg::REF_CNT_W-1:0] rcnt_reg, rcnt_next, ref_r, r_reload;
  logic fr_reg, fr_next;
  logic [spd_pkg::SWAL_W-1:0] swal_val;
  logic [spd_pkg::MAIN_W-1:0] main_val;
  logic bad_setting;

  assign ref_r = ref_latch_reg[spd_pkg::REF_CNT_W-1:0];
  assign r_reload = (ref_r == '0) ? '0 : ref_r - 14'h0001;
  assign swal_val = div_latch_reg[spd_pkg::SWAL_W-1:0];
  assign main_val = div_latch_reg[spd_pkg::DIV_LATCH_W-1:
                                  spd_pkg::DIV_MAIN_LO];
  // prohibited settings are reported, not corrected
  assign bad_setting = ref_r < spd_pkg::REF_MIN ||
                       main_val < spd_pkg::MAIN_MIN ||
                       11'(swal_val) >= main_val;

  assign dif.evt = rise[spd_pkg::PIN_PRE];
  assign dif.run = ctrl_run_reg;
  assign dif.msel = ref_latch_reg[spd_pkg::REF_MSEL_POS];
  assign dif.swal = swal_val;
  assign dif.main_n = main_val;

  spd_divider u_div (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .dif(dif)
  );

  always_comb begin
    rcnt_next = rcnt_reg;
    fr_next = 1'b0;
    if (!ctrl_run_reg) begin
      rcnt_next = r_reload;
    end else if (rise[spd_pkg::PIN_OSC]) begin
      if (rcnt_reg == '0) begin
        fr_next = 1'b1;
        rcnt_next = r_reload;
      end else begin
        rcnt_next = rcnt_reg - 14'h0001;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rcnt_reg <= '0;
      fr_reg <= 1'b0;
    end else if (ce) begin
      rcnt_reg <= rcnt_next;
      fr_reg <= fr_next;
    end
  end

  // ==========================================
  // phase detector and pins
  logic up_reg, up_next, dn_reg, dn_next, inc, dec;

  always_comb begin
    up_next = up_reg | fr_reg;
    dn_next = dn_reg | dif.fp;
    if (up_next && dn_next) begin
      up_next = 1'b0;
      dn_next = 1'b0;
    end
    inc = pol ? up_reg : dn_reg;
    dec = pol ? dn_reg : up_reg;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      up_reg <= 1'b0;
      dn_reg <= 1'b0;
      lock_indicator_out <= 1'b1;
      monitor_out <= 1'b0;
      charge_pump_out <= 1'b0;
      charge_pump_oe <= 1'b0;
      fast_lock_switch_out <= 1'b0;
      fast_lock_switch_oe <= 1'b0;
      phase_ref_out <= 1'b0;
      phase_vco_pull_out <= 1'b0;
      phase_vco_pull_oe <= 1'b0;
      prescaler_high_modulus <= 1'b0;
    end else if (ce) begin
      up_reg <= up_next;
      dn_reg <= dn_next;
      lock_indicator_out <= !(up_reg || dn_reg);
      monitor_out <= pol ? fr_reg : dif.fp;
      charge_pump_out <= inc;
      charge_pump_oe <= inc || dec;
      fast_lock_switch_out <= inc;
      fast_lock_switch_oe <= strobe && (inc || dec);
      phase_ref_out <= dec;
      phase_vco_pull_out <= 1'b0;
      phase_vco_pull_oe <= inc;
      prescaler_high_modulus <= dif.hi_mod;
    end
  end

  assign prescaler_modulus_select = ref_latch_reg[spd_pkg::REF_MSEL_POS];

  // ==========================================
  // axi4-lite slave
  logic aw_have_reg, aw_have_next, w_have_reg, w_have_next;
  logic [ADDR_W-1:0] awaddr_reg, awaddr_next;
  logic [31:0] wdata_reg, wdata_next, rdata_next;
  logic [3:0] wstrb_reg, wstrb_next;
  logic bvalid_next, rvalid_next, awready_next, wready_next, arready_next;
  logic [1:0] bresp_next, rresp_next;
  logic [31:0] status;

  assign status = {25'h0, dif.hi_mod, bad_setting, strobe, pol, dn_reg,
                   up_reg, lock_indicator_out};

  // index 4 marks an unmapped address
  function automatic logic [2:0] decode(input logic [ADDR_W-1:0] a);
    if (a == ADDR_W'(spd_pkg::REG_CTRL)) return 3'h0;
    if (a == ADDR_W'(spd_pkg::REG_REF)) return 3'h1;
    if (a == ADDR_W'(spd_pkg::REG_DIV)) return 3'h2;
    if (a == ADDR_W'(spd_pkg::REG_STAT)) return 3'h3;
    return 3'h4;
  endfunction : decode

  always_comb begin
    aw_have_next = aw_have_reg;
    w_have_next = w_have_reg;
    awaddr_next = awaddr_reg;
    wdata_next = wdata_reg;
    wstrb_next = wstrb_reg;
    bvalid_next = s_axi_bvalid;
    bresp_next = s_axi_bresp;
    rvalid_next = s_axi_rvalid;
    rresp_next = s_axi_rresp;
    rdata_next = s_axi_rdata;
    ctrl_run_next = ctrl_run_reg;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_have_next = 1'b1;
      awaddr_next = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_have_next = 1'b1;
      wdata_next = s_axi_wdata;
      wstrb_next = s_axi_wstrb;
    end
    if (s_axi_bvalid && s_axi_bready)
      bvalid_next = 1'b0;
    if (aw_have_next && w_have_next && !bvalid_next) begin
      aw_have_next = 1'b0;
      w_have_next = 1'b0;
      bvalid_next = 1'b1;
      bresp_next = (decode(awaddr_next) == 3'h4) ?
                   spd_pkg::RESP_SLVERR : spd_pkg::RESP_OKAY;
      if (decode(awaddr_next) == 3'h0 && wstrb_next[0])
        ctrl_run_next = wdata_next[spd_pkg::CTRL_RUN_POS];
    end
    if (s_axi_rvalid && s_axi_rready)
      rvalid_next = 1'b0;
    if (s_axi_arvalid && s_axi_arready) begin
      rvalid_next = 1'b1;
      rresp_next = spd_pkg::RESP_OKAY;
      unique case (decode(s_axi_araddr))
        3'h0: rdata_next = {31'h0, ctrl_run_reg};
        3'h1: rdata_next = {17'h0, ref_latch_reg};
        3'h2: rdata_next = {13'h0, div_latch_reg};
        3'h3: rdata_next = status;
        default: begin
          rdata_next = 32'h0;
          rresp_next = spd_pkg::RESP_SLVERR;
        end
      endcase
    end
    awready_next = !aw_have_next && !bvalid_next;
    wready_next = !w_have_next && !bvalid_next;
    arready_next = !rvalid_next;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_reg <= 1'b0;
      w_have_reg <= 1'b0;
      awaddr_reg <= '0;
      wdata_reg <= 32'h0;
      wstrb_reg <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_arready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= 2'h0;
      s_axi_rdata <= 32'h0;
      ctrl_run_reg <= spd_pkg::CTRL_RUN_RST;
    end else if (ce) begin
      aw_have_reg <= aw_have_next;
      w_have_reg <= w_have_next;
      awaddr_reg <= awaddr_next;
      wdata_reg <= wdata_next;
      wstrb_reg <= wstrb_next;
      s_axi_awready <= awready_next;
      s_axi_wready <= wready_next;
      s_axi_arready <= arready_next;
      s_axi_bvalid <= bvalid_next;
      s_axi_bresp <= bresp_next;
      s_axi_rvalid <= rvalid_next;
      s_axi_rresp <= rresp_next;
      s_axi_rdata <= rdata_next;
      ctrl_run_reg <= ctrl_run_next;
    end
  end

  // ==========================================
  // checks
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_shift;
    ce && rise[spd_pkg::PIN_SCLK] |=>
      shift_reg == 20'({$past(shift_reg), $past(filt_next[0])});
  endproperty
  a_shift: assert property (p_shift)
    else $error("shift clock rise did not shift data in");

  property p_ref_load;
    ce && strobe && shift_reg[0] |=> ref_latch_reg == $past(sr_ref);
  endproperty
  a_ref_load: assert property (p_ref_load)
    else $error("reference latch missed its load");

  property p_div_load;
    ce && strobe && !shift_reg[0] |=>
      div_latch_reg == $past(sr_div) && $stable(ref_latch_reg);
  endproperty
  a_div_load: assert property (p_div_load)
    else $error("divider latch missed its load");

  property p_hold;
    !strobe |=> $stable(ref_latch_reg) && $stable(div_latch_reg);
  endproperty
  a_hold: assert property (p_hold)
    else $error("latch changed without the strobe");

  property p_lock;
    ce && (up_reg || dn_reg) |=> !lock_indicator_out;
  endproperty
  a_lock: assert property (p_lock)
    else $error("lock stayed high during a phase error");

  property p_monitor;
    ce && pol ##0 fr_reg |=> monitor_out;
  endproperty
  a_monitor: assert property (p_monitor)
    else $error("monitor did not follow the reference");

  property p_switch;
    ce && !strobe |=> !fast_lock_switch_oe;
  endproperty
  a_switch: assert property (p_switch)
    else $error("fast-lock switch drove with strobe low");

  property p_open_drain;
    phase_vco_pull_oe |-> !phase_vco_pull_out;
  endproperty
  a_open_drain: assert property (p_open_drain)
    else $error("open-drain output drove high");

  property p_sense;
    ce && !pol && dn_reg |=> charge_pump_oe && charge_pump_out;
  endproperty
  a_sense: assert property (p_sense)
    else $error("inverted pump sense wrong");

  property p_pfd_excl;
    !(up_reg && dn_reg);
  endproperty
  a_pfd_excl: assert property (p_pfd_excl)
    else $error("pump up and down both set");

  c_ref_load: cover property (strobe && shift_reg[0]);
  c_div_load: cover property (strobe && !shift_reg[0]);
  c_lock_drop: cover property ($fell(lock_indicator_out));
  c_write: cover property (s_axi_bvalid && s_axi_bready);
endmodule : spd_core

// ===== rtl/spd_divider.sv
`timescale 1ns/1ps
module spd_divider (
  // clock, reset, enable
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // to the core
  spd_div_if.div dif
);
  logic [8:0] pcnt_reg, pcnt_next;
  logic [7:0] swal_reg, swal_next;
  logic [10:0] main_reg, main_next;
  logic fp_reg, fp_next;
  logic hi_reg, hi_next;

  function automatic logic [8:0] reload(input logic use_small,
                                        input logic hi);
    logic [8:0] base;
    base = use_small ? spd_pkg::PRE_SMALL : spd_pkg::PRE_LARGE;
    return hi ? base : base - 9'h001;
  endfunction : reload

  // ==========================================
  // pulse swallow counting
  always_comb begin
    pcnt_next = pcnt_reg;
    swal_next = swal_reg;
    main_next = main_reg;
    hi_next = hi_reg;
    fp_next = 1'b0;
    if (!dif.run) begin
      swal_next = dif.swal;
      main_next = dif.main_n;
      hi_next = dif.swal != 8'h00;
      pcnt_next = reload(dif.msel, hi_next);
    end else if (dif.evt) begin
      if (pcnt_reg == 9'h000) begin
        // one prescaler period ends
        if (main_reg <= 11'h001) begin
          fp_next = 1'b1;
          main_next = dif.main_n;
          swal_next = dif.swal;
        end else begin
          main_next = main_reg - 11'h001;
          swal_next = (swal_reg != 8'h00) ? swal_reg - 8'h01 : 8'h00;
        end
        hi_next = swal_next != 8'h00;
        pcnt_next = reload(dif.msel, hi_next);
      end else begin
        pcnt_next = pcnt_reg - 9'h001;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pcnt_reg <= 9'h000;
      swal_reg <= 8'h00;
      main_reg <= 11'h000;
      fp_reg <= 1'b0;
      hi_reg <= 1'b0;
    end else if (ce) begin
      pcnt_reg <= pcnt_next;
      swal_reg <= swal_next;
      main_reg <= main_next;
      fp_reg <= fp_next;
      hi_reg <= hi_next;
    end
  end

  assign dif.fp = fp_reg;
  assign dif.hi_mod = hi_reg;

  // ==========================================
  // checks
  property p_hi_swal;
    @(posedge aclk) disable iff (!aresetn)
    hi_reg == (swal_reg != 8'h00);
  endproperty
  a_hi_swal: assert property (p_hi_swal)
    else $error("high modulus out of step with swallow count");

  property p_small_pair;
    @(posedge aclk) disable iff (!aresetn)
    ce && !dif.run && dif.msel |=> pcnt_reg <= 9'h080;
  endproperty
  a_small_pair: assert property (p_small_pair)
    else $error("small pair loaded a large count");

  c_fp: cover property (@(posedge aclk) disable iff (!aresetn) fp_reg);
endmodule : spd_divider

// ===== test/spd_host_model.sv
`timescale 1ns/1ps
// ==========
// host side of the three-wire load link
module spd_host_model (
  // clock and command
  input wire logic aclk,
  input wire logic go,
  input wire logic [19:0] word,
  input wire logic [4:0] nbits,
  // serial pins
  output logic sdata,
  output logic sclk,
  output logic strobe,
  output logic busy
);
  initial begin
    sdata = 1'b0;
    sclk = 1'b0;
    strobe = 1'b0;
    busy = 1'b0;
    forever begin
      @(posedge aclk);
      if (go) begin
        busy <= 1'b1;
        for (int i = int'(nbits) - 1; i >= 0; i--) begin
          sdata <= word[i];
          repeat (6) @(posedge aclk);
          sclk <= 1'b1;
          repeat (6) @(posedge aclk);
          sclk <= 1'b0;
          repeat (6) @(posedge aclk);
        end
        strobe <= 1'b1;
        repeat (8) @(posedge aclk);
        strobe <= 1'b0;
        // released data line shows a changed level, not the last bit
        sdata <= ~sdata;
        busy <= 1'b0;
      end
    end
  end
endmodule : spd_host_model

// ===== test/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  // ==========
  // signals
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, pre, pre_en, himod;
  logic seen_fl = 1'b0;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [1:0] bresp, rresp, rs;
  logic sdata, sclk, strobe, busy, go, pol, osc, osc_en;
  logic lock, mon, cp, cp_oe, fl, fl_oe, pref, ppull, ppull_oe, msel;
  logic [19:0] word;
  logic [4:0] nbits;
  int errors, comparisons;
  // ==========
  // design and host
  spd_core spd_core_i (
    .aclk(aclk), .aresetn(aresetn), .ce(1'b1),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .serial_data_in(sdata),
    .serial_shift_clk(sclk), .latch_load_strobe(strobe),
    .phase_polarity_select(pol), .prescaler_input(pre),
    .reference_osc_input(osc), .lock_indicator_out(lock),
    .monitor_out(mon), .charge_pump_out(cp), .charge_pump_oe(cp_oe),
    .fast_lock_switch_out(fl), .fast_lock_switch_oe(fl_oe),
    .phase_ref_out(pref), .phase_vco_pull_out(ppull),
    .phase_vco_pull_oe(ppull_oe), .prescaler_modulus_select(msel),
    .prescaler_high_modulus(himod)
  );
  spd_host_model spd_host_model_i (
    .aclk(aclk), .go(go), .word(word), .nbits(nbits),
    .sdata(sdata), .sclk(sclk), .strobe(strobe), .busy(busy)
  );
  // ==========
  // clock, oscillator, switch watch
  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end
  initial begin
    osc = 1'b0;
    pre = 1'b0;
    forever begin
      repeat (4) @(posedge aclk);
      osc <= osc_en ? ~osc : 1'b0;
      pre <= pre_en ? ~pre : 1'b0;
    end
  end
  always @(posedge aclk) begin
    if (fl_oe === 1'b1 && fl === cp && cp_oe === 1'b1) seen_fl <= 1'b1;
  end
  // ==========
  // tasks
  task automatic chk(input logic [31:0] got, exp, input string s);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, s, got, exp);
    end
  endtask : chk
  task automatic tmo(input string s);
    errors++;
    $display("MISMATCH t=%0t timeout %s", $time, s);
    give_verdict();
  endtask : tmo
  task automatic axi_wr(input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1 && n < 200);
    rs = bresp;
    bready <= 1'b0;
    if (n >= 200) tmo("write");
  endtask : axi_wr
  task automatic axi_rd(input logic [11:0] a);
    int n;
    n = 0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (arvalid && arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1 && n < 200);
    rd = rdata;
    rs = rresp;
    rready <= 1'b0;
    if (n >= 200) tmo("read");
  endtask : axi_rd
  task automatic send(input logic [19:0] w, input logic [4:0] nb);
    int n;
    n = 0;
    @(posedge aclk);
    word <= w;
    nbits <= nb;
    go <= 1'b1;
    @(posedge aclk);
    go <= 1'b0;
    do begin
      @(posedge aclk);
      n++;
    end while (busy !== 1'b0 && n < 2000);
    if (n >= 2000) tmo("serial");
  endtask : send
  task automatic give_verdict;
    $display("errors=%0d comparisons=%0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : give_verdict
  // ==========
  // sequence
  initial begin
    int n;
    {aresetn, awvalid, wvalid, bready, arvalid, rready, go} = '0;
    {awaddr, araddr, wdata, word, nbits, osc_en, pre_en} = '0;
    pol = 1'b1;
    errors = 0;
    comparisons = 0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk(lock, 1, "lock idle");
    chk(msel, 0, "msel rst");
    chk(fl_oe, 0, "switch off");
    axi_rd(spd_pkg::REG_REF[11:0]);
    chk(rd, 32'h0000_0008, "ref rst");
    axi_rd(spd_pkg::REG_DIV[11:0]);
    chk(rd, 32'h0000_1000, "div rst");
    axi_rd(12'h010);
    chk(rd, 32'h0, "bad rd");
    chk(rs, 2'h2, "bad rd resp");
    axi_wr(12'h010, 32'h1);
    chk(rs, 2'h2, "bad wr");
    axi_wr(spd_pkg::REG_REF[11:0], 32'h7fff);
    chk(rs, 2'h0, "ro wr");
    axi_rd(spd_pkg::REG_REF[11:0]);
    chk(rd, 32'h0000_0008, "ro kept");
    axi_wr(spd_pkg::REG_CTRL[11:0], 32'h0);
    axi_rd(spd_pkg::REG_CTRL[11:0]);
    chk(rd, 32'h0, "run off");
    chk(himod, 0, "low modulus");
    axi_wr(spd_pkg::REG_CTRL[11:0], 32'h1);
    // reference word: modulus select high, ratio 10
    send(20'h08015, 5'd16);
    axi_rd(spd_pkg::REG_REF[11:0]);
    chk(rd, 32'h0000_400a, "ref load");
    chk(msel, 1, "small pair");
    // divider word at the top of both ranges
    send(20'hffffe, 5'd20);
    axi_rd(spd_pkg::REG_DIV[11:0]);
    chk(rd, 32'h0007_ffff, "div max");
    axi_rd(spd_pkg::REG_REF[11:0]);
    chk(rd, 32'h0000_400a, "ref kept");
    send(20'h0280a, 5'd20);
    axi_rd(spd_pkg::REG_DIV[11:0]);
    chk(rd, 32'h0000_1405, "div 20/5");
    chk(fl_oe, 0, "switch off");
    // a stop and restart reloads the divider from the new word
    axi_wr(spd_pkg::REG_CTRL[11:0], 32'h0);
    axi_wr(spd_pkg::REG_CTRL[11:0], 32'h1);
    chk(himod, 1, "high modulus");
    // reference runs, vco side idle: reference leads
    osc_en <= 1'b1;
    n = 0;
    while (lock !== 1'b0 && n < 3000) begin
      @(posedge aclk);
      n++;
    end
    if (n >= 3000) tmo("lock");
    @(posedge aclk);
    chk({cp_oe, cp, pref, ppull_oe}, 4'hd, "pump up");
    chk(ppull, 0, "pull low");
    axi_rd(spd_pkg::REG_STAT[11:0]);
    chk(rd[3:0], 4'ha, "stat up");
    chk(rd[6], 1, "stat high mod");
    n = 0;
    while (mon !== 1'b1 && n < 500) begin
      @(posedge aclk);
      n++;
    end
    chk(n < 500, 1, "mon ref");
    send(20'h0280a, 5'd20);
    chk(seen_fl, 1, "switch on");
    pol <= 1'b0;
    repeat (12) @(posedge aclk);
    chk({cp_oe, cp, pref, ppull_oe}, 4'ha, "pump inv");
    n = 0;
    repeat (200) begin
      @(posedge aclk);
      if (mon !== 1'b0) n++;
    end
    chk(n, 0, "mon vco");
    axi_rd(spd_pkg::REG_STAT[11:0]);
    chk(rd[3], 0, "stat pol");
    // vco side alone: first pulse cancels the pending up, next pumps down
    osc_en <= 1'b0;
    pre_en <= 1'b1;
    n = 0;
    while (mon !== 1'b1 && n < 22000) begin
      @(posedge aclk);
      n++;
    end
    chk(n < 22000, 1, "mon vco pulse");
    repeat (2) @(posedge aclk);
    chk({lock, cp_oe}, 2'h2, "aligned float");
    n = 0;
    while (lock !== 1'b0 && n < 22000) begin
      @(posedge aclk);
      n++;
    end
    if (n >= 22000) tmo("vco lag");
    // 20 x 128 + 5 prescaler cycles of 8 clocks, less the watch offset
    chk(n, (20 * 128 + 5) * 8 - 1, "vco period");
    @(posedge aclk);
    chk({cp_oe, cp, pref, ppull_oe}, 4'hd, "pump dn inv");
    give_verdict();
  end
endmodule : tb_top
